// [iorm_pkg.sv]
// Constants for the I/O page decode and memory map of a small microcontroller.
// Assumes an 11-bit byte address space driven by the CPU core on the same clock.
// Operation
// R1: Lowest 32 addresses form the I/O page
// R2: User EPROM spans 0x0300 to 0x07CF
// R3: Eight bytes 0x07F8-0x07FF hold vectors
// R4: Option byte lives alone at 0x07F1
// R5: Write-only 0x07F0 restarts watchdog, reads nothing
// R6: CPU writes zero to bit 0
// R7: Port A direction: eight read/write bits
// R8: Port B direction: six bits, top two zero
// R9: Software leaves 0x1F and test bits alone
// R10: Unimplemented I/O reads fixed, writes ignored
package iorm_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 2048;
    localparam logic [10:0] IO_PAGE_SIZE = 11'h020;
    localparam logic [10:0] EPROM_FIRST = 11'h300;
    localparam logic [10:0] EPROM_LAST = 11'h7cf;
    localparam logic [10:0] VECTOR_FIRST = 11'h7f8;
    localparam logic [10:0] VECTOR_LAST = 11'h7ff;
    localparam logic [10:0] OPTION_BYTE = 11'h7f1;
    localparam logic [10:0] WATCHDOG_SERVICE = 11'h7f0;
    localparam logic [4:0] PORT_A_VALUE = 5'h00;
    localparam logic [4:0] PORT_B_VALUE = 5'h01;
    localparam logic [4:0] PORT_A_DIRECTION = 5'h04;
    localparam logic [4:0] PORT_B_DIRECTION = 5'h05;
    localparam logic [4:0] TIMER_STATUS_CONTROL = 5'h08;
    localparam logic [4:0] TIMER_COUNT_VALUE = 5'h09;
    localparam logic [4:0] EXT_INT_STATUS_CONTROL = 5'h0a;
    localparam logic [4:0] PORT_A_PULLDOWN_INHIBIT = 5'h10;
    localparam logic [4:0] PORT_B_PULLDOWN_INHIBIT = 5'h11;
    localparam logic [4:0] EPROM_PROGRAM_CONTROL = 5'h18;
    localparam logic [4:0] FACTORY_TEST_RESERVED = 5'h1f;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam int PORT_A_W = 8;
    localparam int PORT_B_W = 6;
    // Timer control field positions
    localparam int TMR_OVF_FLAG = 7;
    localparam int TMR_RTI_FLAG = 6;
    localparam int TMR_OVF_EN = 5;
    localparam int TMR_RTI_EN = 4;
    localparam int TMR_OVF_CLR = 3;
    localparam int TMR_RTI_CLR = 2;
    localparam int TMR_RATE_HI = 1;
    // External interrupt field positions
    localparam int IRQ_EN = 7;
    localparam int IRQ_FLAG = 3;
    localparam int IRQ_CLR = 1;
    // EPROM programming control: latch bit enables array writes
    localparam int PROG_BITS = 3;
    localparam int PROG_LATCH = 2;
    localparam int WATCHDOG_BIT = 0;

    function automatic logic iormIsEprom(input logic [10:0] addr);
        return (addr >= EPROM_FIRST && addr <= EPROM_LAST)
            || (addr >= VECTOR_FIRST && addr <= VECTOR_LAST)
            || (addr == OPTION_BYTE);
    endfunction
endpackage

// [iorm_mem_if.sv]
// Link between the decode logic and the EPROM storage array.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface iorm_mem_if #(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
);
    logic [ADDR_W-1:0] addr;
    logic wrEn;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    modport ctrl (output addr, output wrEn, output wrData, input rdData);
    modport store (input addr, input wrEn, input wrData, output rdData);
endinterface

// [iorm_memory.sv]
// Byte-wide storage for user program, option byte and vectors.
// Assumes the decode side only writes legal EPROM locations.
`timescale 1ns/1ps
module iorm_memory #(
    parameter int DEPTH = 2048,
    parameter int DATA_W = 8
)
(
    input wire logic clock,
    input wire logic reset,
    iorm_mem_if.store bus
);
    logic [DATA_W-1:0] cells [DEPTH];

    always_ff @(posedge clock)
    begin
        if (bus.wrEn)
        begin
            cells[bus.addr] <= bus.wrData;
        end
    end

    // Registered read, one cycle after the address
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            bus.rdData <= '0;
        end
        else
        begin
            bus.rdData <= cells[bus.addr];
        end
    end
endmodule

// [iorm_top.sv]
// I/O page register bank and memory-map decode facing the CPU core.
// Assumes the core bus is on this clock; port pins are asynchronous.
`timescale 1ns/1ps
module iorm_top #(
    parameter int ADDR_W = iorm_pkg::ADDR_W,
    parameter int DATA_W = iorm_pkg::DATA_W
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [DATA_W-1:0] busWrData,
    output logic [DATA_W-1:0] busRdData,
    output logic busRdValid,
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOe,
    input wire logic [5:0] portBIn,
    output logic [5:0] portBOut,
    output logic [5:0] portBOe,
    output logic [7:0] portAPulldownInhibit,
    output logic [5:0] portBPulldownInhibit,
    input wire logic [1:0] timerFlags,
    input wire logic [7:0] timerCount,
    output logic [3:0] timerControl,
    output logic [1:0] timerFlagClear,
    input wire logic irqFlag,
    output logic irqEnable,
    output logic irqFlagClear,
    output logic [2:0] epromProgramBits,
    output logic watchdogRestart
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    generate
        if (ADDR_W != 11 || DATA_W != 8)
        begin : gBadParams
            $error("iorm_top serves only an 11-bit address and 8-bit data");
        end
    endgenerate

    iorm_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) memBus ();

    iorm_memory #(.DEPTH(iorm_pkg::MEM_DEPTH), .DATA_W(DATA_W)) uMemory (
        .clock(clock),
        .reset(reset),
        .bus(memBus)
    );

    logic ioSel;
    logic [4:0] ioReg;
    logic ioWrite;
    logic [7:0] portAMeta, portASync;
    logic [5:0] portBMeta, portBSync;
    logic [7:0] ioReadValue;
    logic [7:0] ioStage;
    logic memSel;
    logic readStage;

    assign ioSel = busAddr < iorm_pkg::IO_PAGE_SIZE; // R1
    assign ioReg = busAddr[4:0];
    assign ioWrite = busWrite && ioSel;

    // Two-stage synchronisers for pin levels
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            portAMeta <= '0;
            portASync <= '0;
            portBMeta <= '0;
            portBSync <= '0;
        end
        else
        begin
            portAMeta <= portAIn;
            portASync <= portAMeta;
            portBMeta <= portBIn;
            portBSync <= portBMeta;
        end
    end

    // Port data and direction
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            portAOut <= iorm_pkg::PORT_RESET;
            portBOut <= '0;
            portAOe <= iorm_pkg::PORT_RESET;
            portBOe <= '0;
        end
        else if (ioWrite)
        begin
            unique case (ioReg)
                iorm_pkg::PORT_A_VALUE: portAOut <= busWrData;
                iorm_pkg::PORT_B_VALUE: portBOut <= busWrData[5:0];
                iorm_pkg::PORT_A_DIRECTION: portAOe <= busWrData; // R7
                iorm_pkg::PORT_B_DIRECTION: portBOe <= busWrData[5:0]; // R8
                default: ; // R10
            endcase
        end
    end

    // Pulldown inhibit, write-only
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            portAPulldownInhibit <= '0;
            portBPulldownInhibit <= '0;
        end
        else if (ioWrite && ioReg == iorm_pkg::PORT_A_PULLDOWN_INHIBIT)
        begin
            portAPulldownInhibit <= busWrData;
        end
        else if (ioWrite && ioReg == iorm_pkg::PORT_B_PULLDOWN_INHIBIT)
        begin
            portBPulldownInhibit <= busWrData[5:0];
        end
    end

    // Timer, interrupt and programming control; clear strobes last one cycle
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            timerControl <= '0;
            timerFlagClear <= '0;
            irqEnable <= 1'b0;
            irqFlagClear <= 1'b0;
            epromProgramBits <= '0;
        end
        else
        begin
            timerFlagClear <= '0;
            irqFlagClear <= 1'b0;
            if (ioWrite && ioReg == iorm_pkg::TIMER_STATUS_CONTROL)
            begin
                timerControl <= {busWrData[iorm_pkg::TMR_OVF_EN],
                    busWrData[iorm_pkg::TMR_RTI_EN],
                    busWrData[iorm_pkg::TMR_RATE_HI -: 2]};
                timerFlagClear <= {busWrData[iorm_pkg::TMR_OVF_CLR],
                    busWrData[iorm_pkg::TMR_RTI_CLR]};
            end
            if (ioWrite && ioReg == iorm_pkg::EXT_INT_STATUS_CONTROL)
            begin
                irqEnable <= busWrData[iorm_pkg::IRQ_EN];
                irqFlagClear <= busWrData[iorm_pkg::IRQ_CLR];
            end
            if (ioWrite && ioReg == iorm_pkg::EPROM_PROGRAM_CONTROL)
            begin
                epromProgramBits <= busWrData[iorm_pkg::PROG_BITS-1:0];
            end
        end
    end

    // Any write to WATCHDOG_SERVICE restarts the watchdog; the core keeps bit 0 low
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            watchdogRestart <= 1'b0;
        end
        else
        begin
            watchdogRestart <= busWrite && busAddr == iorm_pkg::WATCHDOG_SERVICE; // R5 R6
        end
    end

    // Read mux; inputs show pin level, outputs show the latch
    always_comb
    begin
        ioReadValue = iorm_pkg::UNMAPPED_READ; // R10 R9
        unique case (ioReg)
            iorm_pkg::PORT_A_VALUE:
                ioReadValue = (portAOe & portAOut) | (~portAOe & portASync);
            iorm_pkg::PORT_B_VALUE:
                ioReadValue = {2'b00, (portBOe & portBOut) | (~portBOe & portBSync)};
            iorm_pkg::PORT_A_DIRECTION: ioReadValue = portAOe; // R7
            iorm_pkg::PORT_B_DIRECTION: ioReadValue = {2'b00, portBOe}; // R8
            iorm_pkg::TIMER_STATUS_CONTROL:
                ioReadValue = {timerFlags, timerControl[3:2], 2'b00, timerControl[1:0]};
            iorm_pkg::TIMER_COUNT_VALUE: ioReadValue = timerCount;
            iorm_pkg::EXT_INT_STATUS_CONTROL:
                ioReadValue = {irqEnable, 3'b000, irqFlag, 3'b000};
            iorm_pkg::EPROM_PROGRAM_CONTROL: ioReadValue = {5'b00000, epromProgramBits};
            default: ioReadValue = iorm_pkg::UNMAPPED_READ;
        endcase
        if (!ioSel)
        begin
            ioReadValue = iorm_pkg::UNMAPPED_READ;
        end
    end

    // Array written only while the program latch is set
    assign memBus.addr = busAddr;
    assign memBus.wrData = busWrData;
    assign memBus.wrEn = busWrite && epromProgramBits[iorm_pkg::PROG_LATCH]
        && iorm_pkg::iormIsEprom(busAddr); // R2 R3 R4

    // Two-cycle read pipeline so every source lands in a register
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ioStage <= '0;
            memSel <= 1'b0;
            readStage <= 1'b0;
            busRdData <= '0;
            busRdValid <= 1'b0;
        end
        else
        begin
            ioStage <= ioReadValue;
            memSel <= iorm_pkg::iormIsEprom(busAddr); // R2 R3 R4
            readStage <= busRead;
            busRdValid <= readStage;
            busRdData <= memSel ? memBus.rdData : ioStage;
        end
    end

    sequence readOf(logic [10:0] a);
        busRead && !busWrite && busAddr == a;
    endsequence

    wdog_pulse_a: assert property (busWrite && busAddr == iorm_pkg::WATCHDOG_SERVICE // R5
        |=> watchdogRestart) else $error("watchdog restart missing");
    wdog_cause_a: assert property (watchdogRestart // R5
        |-> $past(busWrite) && $past(busAddr) == iorm_pkg::WATCHDOG_SERVICE)
        else $error("watchdog restart without service write");
    wdog_read_a: assert property (readOf(iorm_pkg::WATCHDOG_SERVICE) // R5
        |-> ##2 busRdValid && busRdData == iorm_pkg::UNMAPPED_READ)
        else $error("watchdog location read back a value");
    dira_readback_a: assert property (readOf(11'(iorm_pkg::PORT_A_DIRECTION)) // R7
        |-> ##2 busRdData == $past(portAOe, 2)) else $error("port A direction readback");
    dirb_upper_a: assert property (readOf(11'(iorm_pkg::PORT_B_DIRECTION)) // R8
        |-> ##2 busRdData == {2'b00, $past(portBOe, 2)})
        else $error("port B direction readback");
    unimpl_read_a: assert property (readOf(11'h002) // R10
        |-> ##2 busRdData == iorm_pkg::UNMAPPED_READ) else $error("unimplemented read");
    unimpl_write_a: assert property (busWrite && busAddr == 11'h002 // R10
        |=> $stable({portAOut, portBOut, portAOe, portBOe, timerControl}))
        else $error("unimplemented write had effect");
    read_valid_a: assert property (busRead |-> ##2 busRdValid) // R1
        else $error("read answer not after two cycles");
    eprom_guard_a: assert property (memBus.wrEn |-> iorm_pkg::iormIsEprom(busAddr) // R2
        && epromProgramBits[iorm_pkg::PROG_LATCH]) else $error("array write outside EPROM");
endmodule

// [iorm_cpu_model.sv]
// Behavioural CPU core acting as master on the I/O page bus.
// Assumes the decode takes requests at the rising edge of clock.
`timescale 1ns/1ps
module iorm_cpu_model
(
    input wire logic clock,
    output logic [10:0] busAddr,
    output logic busRead,
    output logic busWrite,
    output logic [7:0] busWrData
);
    initial
    begin
        busAddr = 11'h7ff;
        busRead = 1'b0;
        busWrite = 1'b0;
        busWrData = 8'h00;
    end

    // Factory test location is never touched by software
    function automatic logic isTestLoc(input logic [10:0] addr);
        return addr == {6'h00, iorm_pkg::FACTORY_TEST_RESERVED};
    endfunction

    task automatic writeByte(input logic [10:0] addr, input logic [7:0] data);
        if (isTestLoc(addr))
            return;
        @(posedge clock);
        busAddr <= addr;
        // Watchdog service always carries a zero in bit 0
        busWrData <= (addr == iorm_pkg::WATCHDOG_SERVICE) ? (data & 8'hfe) : data;
        busWrite <= 1'b1;
        @(posedge clock);
        busWrite <= 1'b0;
        // Released lines do not keep the old value
        busWrData <= ~data;
        busAddr <= ~addr;
    endtask

    task automatic readByte(input logic [10:0] addr);
        if (isTestLoc(addr))
            return;
        @(posedge clock);
        busAddr <= addr;
        busRead <= 1'b1;
        @(posedge clock);
        busRead <= 1'b0;
        busAddr <= ~addr;
    endtask
endmodule

// [testbench.sv]
// Self-checking bench for the I/O page decode and memory map.
// Assumes iorm_pkg, iorm_mem_if, iorm_memory and iorm_top are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clock;
    logic reset;
    logic [10:0] busAddr;
    logic busRead;
    logic busWrite;
    logic [7:0] busWrData;
    logic [7:0] busRdData;
    logic busRdValid;
    logic [7:0] portAOe;
    logic [7:0] pinA;
    logic [7:0] portAOut;
    logic [5:0] portBOut;
    logic [5:0] portBOe;
    logic [7:0] portAPulldownInhibit;
    logic [5:0] portBPulldownInhibit;
    logic [3:0] timerControl;
    logic [1:0] timerFlagClear;
    logic irqEnable;
    logic irqFlagClear;
    logic [2:0] epromProgramBits;
    logic [7:0] timerCount;
    logic watchdogRestart;
    logic [7:0] expQ[$];
    logic [7:0] v;
    logic [10:0] unusedLocs[11] = '{11'h002, 11'h003, 11'h006, 11'h00b, 11'h012,
        11'h01e, 11'h020, 11'h0bf, 11'h2ff, 11'h7d0, 11'h7f2};
    logic [10:0] epromLocs[5] = '{11'h300, 11'h7cf, 11'h7f1, 11'h7f8, 11'h7ff};
    int fails;
    int numChecks;
    int seed;

    iorm_cpu_model i_cpu (.clock(clock), .busAddr(busAddr), .busRead(busRead),
        .busWrite(busWrite), .busWrData(busWrData));

    iorm_top i_dut (.clock(clock), .reset(reset), .busAddr(busAddr), .busRead(busRead),
        .busWrite(busWrite), .busWrData(busWrData), .busRdData(busRdData),
        .busRdValid(busRdValid), .portAIn(pinA), .portAOut(portAOut), .portAOe(portAOe),
        .portBIn(6'h00), .portBOut(portBOut), .portBOe(portBOe),
        .portAPulldownInhibit(portAPulldownInhibit),
        .portBPulldownInhibit(portBPulldownInhibit), .timerFlags(2'b00),
        .timerCount(timerCount), .timerControl(timerControl),
        .timerFlagClear(timerFlagClear), .irqFlag(1'b0), .irqEnable(irqEnable),
        .irqFlagClear(irqFlagClear), .epromProgramBits(epromProgramBits),
        .watchdogRestart(watchdogRestart));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [10:0] addr, input logic [7:0] exp);
        expQ.push_back(exp);
        i_cpu.readByte(addr);
    endtask

    task automatic printVerdict;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Each read result is matched against the oldest expectation
    always @(negedge clock)
    begin
        if (busRdValid === 1'b1)
        begin
            if (expQ.size() == 0)
                check(busRdData, 8'hxx);
            else
                check(busRdData, expQ.pop_front());
        end
    end

    initial
    begin
        #20000;
        fails++;
        printVerdict();
    end

    initial
    begin
        seed = 57;
        timerCount = 8'h00;
        pinA = 8'h00;
        reset = 1'b1;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        timerCount <= 8'($random(seed));
        pinA <= 8'($random(seed));
        repeat (4)
        begin
            v = 8'($random(seed));
            i_cpu.writeByte(11'h004, v);
            #1 check(portAOe, v);
            rd(11'h004, v);
            i_cpu.writeByte(11'h005, v);
            #1 check({2'b00, portBOe}, {2'b00, v[5:0]});
            rd(11'h005, {2'b00, v[5:0]});
        end
        rd(11'h009, timerCount);
        // Data latches; port A input bits show the synchronised pin
        i_cpu.writeByte(11'h004, 8'hf0);
        i_cpu.writeByte(11'h000, v);
        #1 check(portAOut, v);
        rd(11'h000, (v & 8'hf0) | (pinA & 8'h0f));
        i_cpu.writeByte(11'h001, v);
        #1 check({2'b00, portBOut}, {2'b00, v[5:0]});
        i_cpu.writeByte(11'h010, v);
        i_cpu.writeByte(11'h011, ~v);
        #1 check(portAPulldownInhibit, v);
        check({2'b00, portBPulldownInhibit}, {2'b00, ~v[5:0]});
        rd(11'h010, 8'h00);
        // Control bits and one-cycle clear strobes
        i_cpu.writeByte(11'h008, 8'hff);
        #1 check({2'b00, timerFlagClear, timerControl}, 8'h3f);
        i_cpu.writeByte(11'h00a, 8'h82);
        #1 check({2'b00, timerFlagClear, 2'b00, irqEnable, irqFlagClear}, 8'h03);
        @(posedge clock);
        #1 check({7'h00, irqFlagClear}, 8'h00);
        rd(11'h008, 8'h33);
        rd(11'h00a, 8'h80);
        i_cpu.writeByte(11'h018, 8'h04);
        #1 check({5'h00, epromProgramBits}, 8'h04);
        foreach (epromLocs[i])
        begin
            v = 8'($random(seed));
            i_cpu.writeByte(epromLocs[i], v);
            rd(epromLocs[i], v);
        end
        // Even with array writes open, holes stay empty
        foreach (unusedLocs[i])
        begin
            i_cpu.writeByte(unusedLocs[i], 8'hff);
            rd(unusedLocs[i], 8'h00);
        end
        // Closed latch leaves the array alone
        i_cpu.writeByte(11'h018, 8'h00);
        i_cpu.writeByte(11'h7ff, ~v);
        rd(11'h7ff, v);
        i_cpu.writeByte(11'h7f0, 8'h00);
        #1 check({7'h00, watchdogRestart}, 8'h01);
        @(posedge clock);
        #1 check({7'h00, watchdogRestart}, 8'h00);
        rd(11'h7f0, 8'h00);
        repeat (4) @(posedge clock);
        // Mid-run reset clears the registers but not the array
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        #1 check(portAOe, 8'h00);
        rd(11'h004, 8'h00);
        rd(11'h7ff, v);
        repeat (4) @(posedge clock);
        check(8'(expQ.size()), 8'h00);
        printVerdict();
    end
endmodule
